// [verilog/dsas_pkg.sv]
/*
  shared constants and types of the delta-sigma adc sequencer:
  register offsets, field positions, reset values, modes, states.
  assumes a 32-bit axi4-lite register bus and one core clock.
*/
package dsas_pkg;

  // register byte offsets
  localparam logic [7:0] DSAS_OFS_CTRL     = 8'h00;
  localparam logic [7:0] DSAS_OFS_CFG      = 8'h04;
  localparam logic [7:0] DSAS_OFS_MUX      = 8'h08;
  localparam logic [7:0] DSAS_OFS_STATUS   = 8'h0c;
  localparam logic [7:0] DSAS_OFS_RESULT   = 8'h10;
  localparam logic [7:0] DSAS_OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] DSAS_OFS_IRQ_EN   = 8'h18;
  localparam logic [7:0] DSAS_OFS_IRQ_CLR  = 8'h1c;

  // control register fields
  localparam int DSAS_CTRL_START = 0;
  localparam int DSAS_CTRL_MODE  = 1;
  localparam int DSAS_CTRL_STOP  = 3;

  // status register fields
  localparam int DSAS_ST_DONE  = 0;
  localparam int DSAS_ST_BUSY  = 1;
  localparam int DSAS_ST_PRIME = 2;
  localparam int DSAS_ST_HOLD  = 3;

  // interrupt event bits
  localparam int DSAS_EV_DONE = 0;
  localparam int DSAS_EV_OVR  = 1;

  // reset values
  localparam logic [1:0] DSAS_MODE_RST = 2'h0;
  localparam logic [3:0] DSAS_RES_RST  = 4'hc;
  localparam logic [3:0] DSAS_MUX_RST  = 4'h0;

  // conversions that only prime the decimator before a result
  localparam logic [1:0] DSAS_PRIME_CNT = 2'h3;

  // axi responses
  localparam logic [1:0] DSAS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] DSAS_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    DSAS_M_SINGLE = 2'h0,
    DSAS_M_MULTI  = 2'h1,
    DSAS_M_CONT   = 2'h2,
    DSAS_M_TURBO  = 2'h3
  } dsas_mode_e;

  typedef enum logic [2:0] {
    DSAS_S_IDLE = 3'b001,
    DSAS_S_RUN  = 3'b010,
    DSAS_S_HOLD = 3'b100
  } dsas_state_e;

  typedef struct packed {
    dsas_mode_e mode;
    logic [3:0] res;
  } dsas_cfg_s;

endpackage

// [verilog/dsas_decim.sv]
/*
  decimator: counts modulator ones over each conversion period and
  sums the four most recent period counts into one result.
  assumes period_end marks the last modulator sample of a period.
*/
`timescale 1ns/1ps
module dsas_decim
  import dsas_pkg::*;
#(
  parameter int RES_MAX = 12
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // control
  input  wire logic               clear,
  input  wire logic               period_end,
  input  wire logic [3:0]         res,
  // modulator stream
  input  wire logic               mod_bit,
  // result
  output logic      [RES_MAX-1:0] result,
  output logic                    result_stb
);

  localparam int AW = RES_MAX - 1;
  localparam int SW = RES_MAX + 1;

  logic [AW-1:0] acc_reg;
  logic [AW-1:0] win_reg [3];
  logic [AW-1:0] fin;
  logic [SW-1:0] total;
  logic [SW-1:0] full;

  always_comb begin
    fin   = acc_reg + AW'(mod_bit);
    total = SW'(win_reg[0]) + SW'(win_reg[1]) + SW'(win_reg[2]) + SW'(fin);
    full  = (SW'(1) << res) - SW'(1);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_reg <= '0;
    end else if (clear || period_end) begin
      acc_reg <= '0;
    end else begin
      acc_reg <= fin;
    end
  end

  // window of four period counts, so each result sees four samples
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      win_reg    <= '{default: '0};
      result     <= '0;
      result_stb <= 1'b0;
    end else begin
      result_stb <= period_end && !clear;
      if (clear) begin
        win_reg <= '{default: '0};
      end else if (period_end) begin
        win_reg[2] <= win_reg[1];
        win_reg[1] <= win_reg[0];
        win_reg[0] <= fin;
        // saturate: full scale has one count more than the code range
        result <= (total > full) ? full[RES_MAX-1:0]
                                 : total[RES_MAX-1:0];
      end
    end
  end

endmodule

// [verilog/dsas_top.sv]
/*
  delta-sigma adc sequencer: trigger handling, single, multi,
  continuous and turbo sequences, priming, done flag, axi4-lite
  registers and interrupt.
  assumes the modulator bit and trigger pin are asynchronous and the
  modulator is clocked at the core clock rate.
*/
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Operation
// - every mode starts on a start-bit write or a trigger input.
// - completion sets status bit and done output until result read.
// - single mode waits idle in standby until triggered.
// - single mode runs four conversions; three prime, fourth gives result.
// - single mode returns to standby after result is read.
// - continuous mode gives first result after three priming periods.
// - continuous mode gives a new result every period, untriggered.
// - multi mode resets converter and re-primes decimator between samples.
// - multi mode starts next sample automatically after each one.
// - after mux change, data invalid until fourth following sample.
// - each result depends on the four latest period samples.
// - 12-bit results supported; lower resolutions run faster.
// - done output rises at every result, not at priming ends, also continuous.
// - trigger is optional in continuous mode; may be tied low.
module dsas_top
  import dsas_pkg::*;
#(
  parameter int RES_MAX = 12,
  parameter int RES_MIN = 8
) (
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  // axi4-lite write address and data
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [7:0]  AWADDR,
  input  wire logic [2:0]  AWPROT,
  input  wire logic        WVALID,
  output logic             WREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  // axi4-lite write response
  output logic             BVALID,
  input  wire logic        BREADY,
  output logic [1:0]       BRESP,
  // axi4-lite read
  input  wire logic        ARVALID,
  output logic             ARREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic [2:0]  ARPROT,
  output logic             RVALID,
  input  wire logic        RREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  // converter side
  input  wire logic        MOD_BIT,
  input  wire logic        SOC,
  output logic             CONV_RST,
  output logic [3:0]       MUX_SEL,
  // completion
  output logic             EOC,
  output logic             IRQ
);

  initial begin
    if (RES_MAX < RES_MIN || RES_MIN < 3 || RES_MAX > 15)
      $error("dsas_top: unsupported resolution range");
  end

  dsas_state_e         state_reg;
  dsas_cfg_s           cfg_reg;
  logic [3:0]          mux_reg;
  logic [1:0]          conv_cnt_reg;
  logic [RES_MAX-3:0]  per_cnt_reg;
  logic                reprime_reg;
  logic [RES_MAX-1:0]  data_reg;
  logic                done_reg;
  logic [1:0]          irq_stat_reg;
  logic [1:0]          irq_en_reg;
  logic                irq_reg;
  logic                conv_rst_reg;
  logic [2:0]          soc_sync_reg;
  logic [1:0]          mod_sync_reg;
  logic                aw_have_reg;
  logic                w_have_reg;
  logic [7:0]          aw_addr_reg;
  logic [31:0]         w_data_reg;
  logic [3:0]          w_strb_reg;
  logic                awready_reg;
  logic                wready_reg;
  logic                bvalid_reg;
  logic [1:0]          bresp_reg;
  logic                arready_reg;
  logic                rvalid_reg;
  logic [31:0]         rdata_reg;
  logic [1:0]          rresp_reg;

  logic                wr_do;
  logic                wr_lo;
  logic                rd_do;
  logic                rd_result;
  logic                start_wr;
  logic                stop_wr;
  logic                mux_wr;
  logic                soc_rise;
  logic                trig;
  logic                running;
  logic                period_end;
  logic                dec_clear;
  logic [RES_MAX-3:0]  per_last;
  logic [RES_MAX-1:0]  dec_result;
  logic                dec_stb;
  logic                result_ev;
  logic                done_set;

  // register bus decode
  always_comb begin
    wr_do     = aw_have_reg && w_have_reg && !bvalid_reg;
    wr_lo     = wr_do && w_strb_reg[0];
    rd_do     = ARVALID && arready_reg;
    rd_result = rd_do && ARADDR == DSAS_OFS_RESULT;
    start_wr  = wr_lo && aw_addr_reg == DSAS_OFS_CTRL
                && w_data_reg[DSAS_CTRL_START];
    stop_wr   = wr_lo && aw_addr_reg == DSAS_OFS_CTRL
                && w_data_reg[DSAS_CTRL_STOP];
    mux_wr    = wr_lo && aw_addr_reg == DSAS_OFS_MUX
                && w_data_reg[3:0] != mux_reg;
  end

  // pins pass two flops before use; third flop only for the edge
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      soc_sync_reg <= '0;
      mod_sync_reg <= '0;
    end else begin
      soc_sync_reg <= {soc_sync_reg[1:0], SOC};
      mod_sync_reg <= {mod_sync_reg[0], MOD_BIT};
    end
  end

  // an unconnected trigger tied low simply never fires
  always_comb begin
    soc_rise   = soc_sync_reg[1] && !soc_sync_reg[2];
    trig       = start_wr || soc_rise;
    running    = state_reg == DSAS_S_RUN;
    per_last   = (RES_MAX-2)'((RES_MAX-2)'(1) << (cfg_reg.res - 4'h2))
                 - (RES_MAX-2)'(1);
    period_end = running && !reprime_reg && per_cnt_reg == per_last;
    dec_clear  = !running || reprime_reg;
    result_ev  = dec_stb && running && conv_cnt_reg == DSAS_PRIME_CNT
                 && !mux_wr;
    done_set   = result_ev;
  end

  // sequencer
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      state_reg    <= DSAS_S_IDLE;
      conv_cnt_reg <= '0;
      reprime_reg  <= 1'b0;
      data_reg     <= '0;
    end else begin
      reprime_reg <= 1'b0;
      unique case (state_reg)
        DSAS_S_IDLE: begin
          // standby: nothing runs until a trigger
          conv_cnt_reg <= '0;
          if (trig && !stop_wr) begin
            state_reg <= DSAS_S_RUN;
          end
        end
        DSAS_S_RUN: begin
          // triggers are not looked at here
          if (stop_wr) begin
            state_reg <= DSAS_S_IDLE;
          end else if (mux_wr) begin
            conv_cnt_reg <= '0;
          end else if (dec_stb) begin
            if (conv_cnt_reg != DSAS_PRIME_CNT) begin
              conv_cnt_reg <= conv_cnt_reg + 2'h1;
            end else begin
              data_reg <= dec_result;
              unique case (cfg_reg.mode)
                DSAS_M_SINGLE: state_reg <= DSAS_S_HOLD;
                DSAS_M_CONT:   conv_cnt_reg <= DSAS_PRIME_CNT;
                DSAS_M_MULTI, DSAS_M_TURBO: begin
                  // clean start per sample, no old history
                  conv_cnt_reg <= '0;
                  reprime_reg  <= 1'b1;
                end
              endcase
            end
          end
        end
        DSAS_S_HOLD: begin
          if (rd_result || stop_wr) begin
            state_reg <= DSAS_S_IDLE;
          end
        end
      endcase
    end
  end

  // conversion period timer; at a 10 mhz core clock the 12-bit rate is
  // far below the fast modulator rate, trading speed for one clock
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      per_cnt_reg <= '0;
    end else if (dec_clear || period_end) begin
      per_cnt_reg <= '0;
    end else begin
      per_cnt_reg <= per_cnt_reg + (RES_MAX-2)'(1);
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      conv_rst_reg <= 1'b1;
    end else begin
      conv_rst_reg <= dec_clear;
    end
  end

  dsas_decim #(
    .RES_MAX    (RES_MAX)
  ) u_decim (
    .clk        (CORE_CLK),
    .rst        (RST),
    .clear      (dec_clear),
    .period_end (period_end),
    .res        (cfg_reg.res),
    .mod_bit    (mod_sync_reg[1]),
    .result     (dec_result),
    .result_stb (dec_stb)
  );

  // done flag: a new result wins over a read in the same cycle
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      done_reg <= 1'b0;
    end else if (done_set) begin
      done_reg <= 1'b1;
    end else if (rd_result) begin
      done_reg <= 1'b0;
    end
  end

  // sticky events, write-one clear loses to a new event
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      irq_stat_reg <= '0;
      irq_reg      <= 1'b0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == DSAS_EV_DONE && done_set)
            || (i == DSAS_EV_OVR && done_set && done_reg && !rd_result)) begin
          irq_stat_reg[i] <= 1'b1;
        end else if (wr_lo && aw_addr_reg == DSAS_OFS_IRQ_CLR
                     && w_data_reg[i]) begin
          irq_stat_reg[i] <= 1'b0;
        end
      end
      irq_reg <= |(irq_stat_reg & irq_en_reg);
    end
  end

  // software-written configuration
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      cfg_reg.mode <= dsas_mode_e'(DSAS_MODE_RST);
      cfg_reg.res  <= DSAS_RES_RST;
      mux_reg      <= DSAS_MUX_RST;
      irq_en_reg   <= '0;
    end else if (wr_lo) begin
      unique case (aw_addr_reg)
        DSAS_OFS_CTRL:
          cfg_reg.mode <= dsas_mode_e'(w_data_reg[DSAS_CTRL_MODE +: 2]);
        DSAS_OFS_CFG:
          if (w_data_reg[3:0] >= 4'(RES_MIN)
              && w_data_reg[3:0] <= 4'(RES_MAX)) begin
            cfg_reg.res <= w_data_reg[3:0];
          end
        DSAS_OFS_MUX:    mux_reg    <= w_data_reg[3:0];
        DSAS_OFS_IRQ_EN: irq_en_reg <= w_data_reg[1:0];
        default: ;
      endcase
    end
  end

  // axi write channels, taken in either order
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg  <= '0;
      w_strb_reg  <= '0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= DSAS_RESP_OKAY;
    end else begin
      if (AWVALID && awready_reg) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= AWADDR;
        awready_reg <= 1'b0;
      end else if (wr_do) begin
        aw_have_reg <= 1'b0;
      end else if (!aw_have_reg && !bvalid_reg) begin
        awready_reg <= 1'b1;
      end
      if (WVALID && wready_reg) begin
        w_have_reg <= 1'b1;
        w_data_reg <= WDATA;
        w_strb_reg <= WSTRB;
        wready_reg <= 1'b0;
      end else if (wr_do) begin
        w_have_reg <= 1'b0;
      end else if (!w_have_reg && !bvalid_reg) begin
        wready_reg <= 1'b1;
      end
      if (wr_do) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= (aw_addr_reg[1:0] != 2'h0
                       || aw_addr_reg > DSAS_OFS_IRQ_CLR
                       || aw_addr_reg == DSAS_OFS_STATUS
                       || aw_addr_reg == DSAS_OFS_RESULT
                       || aw_addr_reg == DSAS_OFS_IRQ_STAT)
                      ? DSAS_RESP_SLVERR : DSAS_RESP_OKAY;
      end else if (BVALID && BREADY) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // axi read channel; reading the result is what the done flag waits on
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= '0;
      rresp_reg   <= DSAS_RESP_OKAY;
    end else begin
      if (rd_do) begin
        arready_reg <= 1'b0;
        rvalid_reg  <= 1'b1;
        rresp_reg   <= DSAS_RESP_OKAY;
        unique case (ARADDR)
          DSAS_OFS_CTRL:
            rdata_reg <= 32'(cfg_reg.mode) << DSAS_CTRL_MODE;
          DSAS_OFS_CFG:      rdata_reg <= 32'(cfg_reg.res);
          DSAS_OFS_MUX:      rdata_reg <= 32'(mux_reg);
          DSAS_OFS_STATUS: begin
            rdata_reg <= '0;
            rdata_reg[DSAS_ST_DONE]  <= done_reg;
            rdata_reg[DSAS_ST_BUSY]  <= state_reg != DSAS_S_IDLE;
            rdata_reg[DSAS_ST_PRIME] <= running
                                        && conv_cnt_reg != DSAS_PRIME_CNT;
            rdata_reg[DSAS_ST_HOLD]  <= state_reg == DSAS_S_HOLD;
          end
          DSAS_OFS_RESULT:   rdata_reg <= 32'(data_reg);
          DSAS_OFS_IRQ_STAT: rdata_reg <= 32'(irq_stat_reg);
          DSAS_OFS_IRQ_EN:   rdata_reg <= 32'(irq_en_reg);
          DSAS_OFS_IRQ_CLR:  rdata_reg <= '0;
          default: begin
            rdata_reg <= '0;
            rresp_reg <= DSAS_RESP_SLVERR;
          end
        endcase
      end else if (RVALID && RREADY) begin
        rvalid_reg <= 1'b0;
      end else if (!rvalid_reg) begin
        arready_reg <= 1'b1;
      end
    end
  end

  // outputs straight from flops
  always_comb begin
    AWREADY  = awready_reg;
    WREADY   = wready_reg;
    BVALID   = bvalid_reg;
    BRESP    = bresp_reg;
    ARREADY  = arready_reg;
    RVALID   = rvalid_reg;
    RDATA    = rdata_reg;
    RRESP    = rresp_reg;
    CONV_RST = conv_rst_reg;
    MUX_SEL  = mux_reg;
    EOC      = done_reg;
    IRQ      = irq_reg;
  end

endmodule

// [dv/dsas_top_chk.sv]
/*
  port checker for the adc sequencer top.
  assumes a bind from the bench and PERIOD clocks per conversion.
*/
`timescale 1ns/1ps
module dsas_top_chk
  import dsas_pkg::*;
#(
  parameter int PERIOD = 64
) (
  // clock and reset
  input wire logic        CORE_CLK,
  input wire logic        RST,
  // register bus
  input wire logic        AWVALID,
  input wire logic        AWREADY,
  input wire logic        WVALID,
  input wire logic        WREADY,
  input wire logic        BVALID,
  input wire logic        BREADY,
  input wire logic        ARVALID,
  input wire logic        ARREADY,
  input wire logic [7:0]  ARADDR,
  input wire logic        RVALID,
  input wire logic        RREADY,
  input wire logic [31:0] RDATA,
  input wire logic [1:0]  RRESP,
  // converter side
  input wire logic        CONV_RST,
  input wire logic [3:0]  MUX_SEL,
  input wire logic        EOC
);
  logic [9:0] run_cnt_reg;
  wire        rd_res = ARVALID && ARREADY && ARADDR == DSAS_OFS_RESULT;

  // saturates so continuous runs never wrap back under the bound
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST || CONV_RST) run_cnt_reg <= 10'h000;
    else if (run_cnt_reg != 10'h3ff) run_cnt_reg <= run_cnt_reg + 10'h001;
  end

  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  chk_eoc_sticky: assert property (
    $fell(EOC) |-> $past(rd_res) || $past(BVALID) || BVALID)
    else $error("done output dropped without a result read");
  chk_prime_len: assert property (
    $rose(EOC) |-> run_cnt_reg >= 4 * PERIOD - 8)
    else $error("result came before four conversion periods");
  chk_mux_write: assert property (
    $changed(MUX_SEL) |-> BVALID)
    else $error("mux select changed without a write");
  chk_b_latency: assert property (
    AWVALID && AWREADY && WVALID && WREADY |=> ##1 BVALID)
    else $error("write response late");
  chk_b_single: assert property (BVALID && BREADY |=> !BVALID)
    else $error("write response repeated");
  chk_r_latency: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read data late");
  chk_r_single: assert property (RVALID && RREADY |=> !RVALID)
    else $error("read data repeated");
  chk_unmapped_rd: assert property (
    ARVALID && ARREADY && ARADDR > 8'h1c |=>
      RRESP == DSAS_RESP_SLVERR && RDATA == 32'h0)
    else $error("unmapped read not refused");
endmodule

// [dv/dsas_partner.sv]
/*
  far-side model: modulator bit stream of fixed ones density and a
  trigger source. assumes one clock shared with the sequencer.
*/
`timescale 1ns/1ps
module dsas_partner (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // bench control
  input  wire logic       trig,
  input  wire logic [3:0] density,
  // toward the sequencer
  output logic            soc,
  output logic            mod_bit
);
  logic [2:0] phase_reg;
  logic [2:0] soc_cnt_reg;

  // any 256-sample window then holds exactly 32*density ones for density up to 8
  always_ff @(posedge clk or posedge rst) begin
    if (rst) phase_reg <= 3'h0;
    else phase_reg <= phase_reg + 3'h1;
  end
  assign mod_bit = {1'b0, phase_reg} < density;

  // stretched so the two-stage input sync cannot miss it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) soc_cnt_reg <= 3'h0;
    else if (trig) soc_cnt_reg <= 3'h4;
    else if (soc_cnt_reg != 3'h0) soc_cnt_reg <= soc_cnt_reg - 3'h1;
  end
  assign soc = soc_cnt_reg != 3'h0;
endmodule

// [dv/dsas_top_tb.sv]
/*
  self-checking bench for the adc sequencer top.
  assumes the partner model for modulator and trigger, res=8.
*/
`timescale 1ns/1ps
module dsas_top_tb;
  import dsas_pkg::*;
  localparam int P = 64;
  logic        CORE_CLK = 1'b0, RST = 1'b1;
  logic        AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
  logic        ARVALID = 1'b0, RREADY = 1'b0, trig = 1'b0;
  logic [7:0]  AWADDR = 8'h00, ARADDR = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic [3:0]  dens = 4'h4;
  logic        conv_q = 1'b1;
  wire         AWREADY, WREADY, BVALID, ARREADY, RVALID, SOC, MOD_BIT;
  wire         CONV_RST, EOC, IRQ;
  wire  [1:0]  BRESP, RRESP;
  wire  [31:0] RDATA;
  wire  [3:0]  MUX_SEL;
  int          fails = 0, check_count = 0, conv_rises = 0;

  always #50 CORE_CLK = ~CORE_CLK;
  always @(posedge CORE_CLK) begin
    conv_q <= CONV_RST;
    if (CONV_RST && !conv_q) conv_rises++;
  end

  dsas_top uut (.CORE_CLK(CORE_CLK), .RST(RST), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .AWADDR(AWADDR), .AWPROT(3'h0), .WVALID(WVALID),
    .WREADY(WREADY), .WDATA(WDATA), .WSTRB(4'hf), .BVALID(BVALID),
    .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .ARADDR(ARADDR), .ARPROT(3'h0), .RVALID(RVALID), .RREADY(RREADY),
    .RDATA(RDATA), .RRESP(RRESP), .MOD_BIT(MOD_BIT), .SOC(SOC),
    .CONV_RST(CONV_RST), .MUX_SEL(MUX_SEL), .EOC(EOC), .IRQ(IRQ));
  dsas_partner u_far (.clk(CORE_CLK), .rst(RST), .trig(trig),
    .density(dens), .soc(SOC), .mod_bit(MOD_BIT));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bail(input int i);
    if (i >= 3000) begin
      fails++;
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int i;
    @(posedge CORE_CLK);
    AWVALID <= 1'b1; AWADDR <= a; WVALID <= 1'b1; WDATA <= d;
    BREADY <= 1'b1;
    for (i = 0; i < 3000; i++) begin
      @(posedge CORE_CLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
      if (BVALID) break;
    end
    bail(i);
    r = BRESP;
    BREADY <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int i;
    @(posedge CORE_CLK);
    ARVALID <= 1'b1; ARADDR <= a; RREADY <= 1'b1;
    for (i = 0; i < 3000; i++) begin
      @(posedge CORE_CLK);
      if (ARREADY) ARVALID <= 1'b0;
      if (RVALID) break;
    end
    bail(i);
    d = RDATA;
    r = RRESP;
    RREADY <= 1'b0;
  endtask
  task automatic wait_eoc(output int n);
    for (n = 0; EOC !== 1'b1 && n < 3000; n++) @(posedge CORE_CLK);
    bail(n);
  endtask
  task automatic rd_res(input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(DSAS_OFS_RESULT, d, r);
    chk(d, exp);
    chk(32'(EOC), 32'h0);
  endtask

  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    rd(DSAS_OFS_CFG, d, r);
    chk(d, 32'(DSAS_RES_RST));
    rd(DSAS_OFS_MUX, d, r);
    chk(d, 32'(DSAS_MUX_RST));
    rd(8'h20, d, r);
    chk(32'(r), 32'(DSAS_RESP_SLVERR));
    wr(DSAS_OFS_STATUS, 32'h1, r);
    chk(32'(r), 32'(DSAS_RESP_SLVERR));
    wr(DSAS_OFS_CFG, 32'h8, r);
    wr(DSAS_OFS_CFG, 32'hf, r);
    rd(DSAS_OFS_CFG, d, r);
    chk(d, 32'h8);
    $display("test registers done");
  endtask

  task automatic t_single;
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    wr(DSAS_OFS_CTRL, 32'h0, r);
    repeat (300) @(posedge CORE_CLK);
    chk(32'({EOC, CONV_RST}), 32'h1);
    trig <= 1'b1;
    @(posedge CORE_CLK) trig <= 1'b0;
    wait_eoc(n);
    chk(32'(n >= 4 * P - 8 && n <= 4 * P + 16), 32'h1);
    rd_res(32'h80);
    chk(32'(IRQ), 32'h0); // masked event
    wr(DSAS_OFS_IRQ_CLR, 32'h3, r);
    wr(DSAS_OFS_IRQ_EN, 32'h1, r);
    wr(DSAS_OFS_CTRL, 32'h1, r);
    repeat (100) @(posedge CORE_CLK);
    trig <= 1'b1;
    @(posedge CORE_CLK) trig <= 1'b0;
    wait_eoc(n);
    chk(32'(n < 4 * P), 32'h1);
    repeat (2) @(posedge CORE_CLK);
    chk(32'(IRQ), 32'h1);
    rd(DSAS_OFS_STATUS, d, r);
    chk(d & 32'h9, 32'h9);
    rd(DSAS_OFS_IRQ_STAT, d, r);
    chk(d, 32'h1);
    wr(DSAS_OFS_IRQ_CLR, 32'h1, r);
    repeat (2) @(posedge CORE_CLK);
    chk(32'(IRQ), 32'h0);
    rd_res(32'h80);
    repeat (5 * P) @(posedge CORE_CLK);
    chk(32'({EOC, CONV_RST}), 32'h1);
    $display("test single done");
  endtask

  task automatic t_cont;
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    wr(DSAS_OFS_CTRL, 32'h5, r); // trigger pin stays low
    wait_eoc(n);
    chk(32'(n >= 4 * P - 12 && n <= 4 * P + 16), 32'h1);
    for (int k = 0; k < 3; k++) begin
      rd_res(32'h80);
      wait_eoc(n);
      chk(32'(n >= P - 10 && n <= P + 2), 32'h1);
    end
    // leave one result unread so the next one counts as an overrun
    repeat (P + 4) @(posedge CORE_CLK);
    rd(DSAS_OFS_IRQ_STAT, d, r);
    chk(d & 32'h2, 32'h2);
    rd_res(32'h80);
    wr(DSAS_OFS_MUX, 32'h5, r);
    chk(32'(MUX_SEL), 32'h5);
    wait_eoc(n);
    chk(32'(n >= 3 * P), 32'h1);
    rd_res(32'h80);
    wr(DSAS_OFS_CTRL, 32'h8, r);
    repeat (4) @(posedge CORE_CLK);
    chk(32'(CONV_RST), 32'h1);
    $display("test continuous done");
  endtask

  task automatic t_multi;
    logic [1:0] r;
    int         n;
    int         c0;
    for (int m = 1; m < 4; m += 2) begin
      wr(DSAS_OFS_CTRL, 32'(m * 2 + 1), r);
      wait_eoc(n);
      c0 = conv_rises;
      rd_res(32'h80);
      wait_eoc(n);
      chk(32'(conv_rises - c0), 32'h1);
      chk(32'(n >= 4 * P - 12 && n <= 4 * P + 16), 32'h1);
      rd_res(32'h80);
      wr(DSAS_OFS_CTRL, 32'h8, r);
      if (EOC === 1'b1) rd_res(32'h80);
    end
    $display("test multi done");
  endtask

  initial begin
    repeat (20) @(posedge CORE_CLK);
    RST <= 1'b0;
    t_regs();
    t_single();
    t_cont();
    t_multi();
    tally_and_finish();
  end
endmodule

bind dsas_top dsas_top_chk #(.PERIOD(64)) u_chk (.*);
